// ===== hdl/labx_exec.sv
// Execution datapath: add, register AND, literal AND and bit clear.
// Assumes the core presents the instruction and the file operand
// together with a one-cycle strobe in the last oscillator period.
`timescale 1ns/1ns

// Functional notes
// - Register AND: accumulator AND file to destination
// - Destination bit zero writes accumulator only
// - Destination bit one writes file register
// - Literal AND into accumulator, zero flag only
// - One instruction cycle of four oscillator periods
// - Byte format: opcode, d at 5, file 4:0
// - Bit format: opcode 11:8, bit 7:5
// - Literal format: opcode 11:8, literal 7:0
module labx_exec #(
    parameter int OSC_PER_CYCLE = labx_pkg::LABX_OSC_PER_CYCLE
) (
    input wire logic clk_sys,                          // Oscillator clock
    input wire logic sys_rst,                          // Async reset
    input wire logic [labx_pkg::LABX_IW-1:0] instr,    // Instruction word
    input wire logic instr_valid,                      // Instruction present
    input wire logic [labx_pkg::LABX_DW-1:0] file_rd,  // Addressed file data
    output logic [labx_pkg::LABX_FAW-1:0] file_addr_r, // File address
    output logic [labx_pkg::LABX_DW-1:0] file_wdata_r, // File write data
    output logic file_we_r,                            // File write strobe
    output logic [labx_pkg::LABX_DW-1:0] acc_r,        // Accumulator
    output logic zero_flag_r,                          // Zero flag
    output logic carry_flag_r,                         // Carry flag
    output logic digit_carry_flag_r,                   // Low nibble carry
    output logic done_r                                // Instruction retired
);
    import labx_pkg::*;

    // Needs OSC_PER_CYCLE of two or more; one period leaves no counter.
    localparam int PW = $clog2(OSC_PER_CYCLE);

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    labx_op_t op;
    logic dest_reg;
    logic [LABX_FAW-1:0] faddr;
    logic [LABX_BW-1:0] bit_idx;
    logic [LABX_DW-1:0] literal;
    logic [PW-1:0] phase_r;
    logic last_phase;
    logic take;
    logic [LABX_DW:0] sum;
    logic [4:0] low_sum;
    logic [LABX_DW-1:0] result;
    logic to_file;
    logic upd_z;
    logic upd_c;
    logic [LABX_DW-1:0] keep_mask;
    logic wr_acc;
    logic wr_file;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    // Pure slicing and compares; no register stage in the decode.
    labx_decode u_decode (
        .instr(instr),
        .op(op),
        .dest_reg(dest_reg),
        .faddr(faddr),
        .bit_idx(bit_idx),
        .literal(literal)
    );

    // ------------------------------------------------------------
    // Instruction cycle sequencing
    // ------------------------------------------------------------
    // Results commit only in the last period so one instruction
    // takes exactly one full instruction cycle.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= '0;
        end else if (last_phase) begin
            phase_r <= '0;
        end else begin
            phase_r <= PW'(phase_r + 1'b1);
        end
    end

    assign last_phase = (phase_r == PW'(OSC_PER_CYCLE - 1));
    assign take = last_phase && instr_valid;

    // Accumulator is the destination unless the result goes to file
    function automatic logic acc_dest(labx_op_t o, logic f);
        return (o != LABX_NONE) && (o != LABX_BCLR) && !f;
    endfunction

    assign wr_acc = take && acc_dest(op, to_file);
    assign wr_file = take && to_file;

    // ------------------------------------------------------------
    // Arithmetic and logic
    // ------------------------------------------------------------
    // Extra top bit of each sum is the carry out of that width
    assign sum = {1'b0, acc_r} + {1'b0, file_rd};
    assign low_sum = {1'b0, acc_r[3:0]} + {1'b0, file_rd[3:0]};

    // One keep bit per data bit; only the indexed bit drops out
    for (genvar i = 0; i < LABX_DW; i++) begin : g_keep
        assign keep_mask[i] = (bit_idx != LABX_BW'(i));
    end

    always_comb begin
        result = acc_r;
        to_file = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        case (op)
            LABX_ADD: begin
                result = sum[LABX_DW-1:0];
                to_file = dest_reg;
                upd_z = 1'b1;
                upd_c = 1'b1;
            end
            LABX_ANDR: begin
                result = acc_r & file_rd;
                to_file = dest_reg;
                upd_z = 1'b1;
            end
            LABX_ANDL: begin
                result = acc_r & literal;
                upd_z = 1'b1;
            end
            LABX_BCLR: begin
                result = file_rd & keep_mask;
                to_file = 1'b1;
            end
            default: begin
                result = acc_r;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    // Bit clear and file-bound results leave the accumulator alone
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= LABX_ACC_RST;
        end else if (wr_acc) begin
            acc_r <= result;
        end
    end

    // ------------------------------------------------------------
    // File write port
    // ------------------------------------------------------------
    // Address follows every edge; only the strobe qualifies it,
    // so the file must latch on file_we_r and nothing else.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            file_we_r <= 1'b0;
        end else begin
            file_we_r <= wr_file;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            file_addr_r <= '0;
        end else begin
            file_addr_r <= faddr;
        end
    end

    // Data holds between writes, which saves a mux on the file side
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            file_wdata_r <= '0;
        end else if (wr_file) begin
            file_wdata_r <= result;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Zero follows every add and AND result, file-bound ones too; bit clear leaves it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            zero_flag_r <= 1'b0;
        end else if (take && upd_z) begin
            zero_flag_r <= (result == '0);
        end
    end

    // Carry and nibble carry move on add only
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            carry_flag_r <= 1'b0;
        end else if (take && upd_c) begin
            carry_flag_r <= sum[LABX_DW];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            digit_carry_flag_r <= 1'b0;
        end else if (take && upd_c) begin
            digit_carry_flag_r <= low_sum[4];
        end
    end

    // ------------------------------------------------------------
    // Retire strobe
    // ------------------------------------------------------------
    // Pulses for unknown words too, so the core never stalls on them
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= take;
        end
    end

endmodule // labx_exec

// ===== hdl/labx_pkg.sv
// Shared constants for the four-instruction execution datapath.
// Assumes a 12-bit instruction word and an 8-bit data path.
package labx_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int LABX_IW = 12;
    localparam int LABX_DW = 8;
    localparam int LABX_FAW = 5;
    localparam int LABX_BW = 3;

    // ------------------------------------------------------------
    // Opcode field positions
    // ------------------------------------------------------------
    localparam int LABX_BYTE_OP_HI = 11;
    localparam int LABX_BYTE_OP_LO = 6;
    localparam int LABX_DEST_POS = 5;
    localparam int LABX_FILE_HI = 4;
    localparam int LABX_NIB_OP_HI = 11;
    localparam int LABX_NIB_OP_LO = 8;
    localparam int LABX_BIT_HI = 7;
    localparam int LABX_BIT_LO = 5;
    localparam int LABX_LIT_HI = 7;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] LABX_OP_ANDWR = 6'h05;
    localparam logic [5:0] LABX_OP_ADDWR = 6'h07;
    localparam logic [3:0] LABX_OP_ANDLIT = 4'he;
    localparam logic [3:0] LABX_OP_BITCLR = 4'h4;

    // ------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------
    localparam int LABX_OSC_PER_CYCLE = 4;
    localparam logic [7:0] LABX_ACC_RST = 8'h00;

    typedef enum logic [2:0] {
        LABX_NONE = 3'b000,
        LABX_ADD = 3'b001,
        LABX_ANDR = 3'b010,
        LABX_ANDL = 3'b011,
        LABX_BCLR = 3'b100
    } labx_op_t;

endpackage

// ===== hdl/labx_decode.sv
// Decoder of the 12-bit instruction word into operation and fields.
// Assumes a word that is stable for a whole instruction cycle.
`timescale 1ns/1ns
module labx_decode (
    input wire logic [labx_pkg::LABX_IW-1:0] instr, // Instruction word
    output labx_pkg::labx_op_t op,                  // Decoded operation
    output logic dest_reg,                          // Result to file
    output logic [labx_pkg::LABX_FAW-1:0] faddr,    // File address
    output logic [labx_pkg::LABX_BW-1:0] bit_idx,   // Bit index
    output logic [labx_pkg::LABX_DW-1:0] literal    // Immediate
);
    import labx_pkg::*;

    always_comb begin
        op = LABX_NONE;
        if (instr[LABX_BYTE_OP_HI:LABX_BYTE_OP_LO] == LABX_OP_ADDWR) begin
            op = LABX_ADD;
        end else if (instr[LABX_BYTE_OP_HI:LABX_BYTE_OP_LO]
                     == LABX_OP_ANDWR) begin
            op = LABX_ANDR;
        end else if (instr[LABX_NIB_OP_HI:LABX_NIB_OP_LO]
                     == LABX_OP_ANDLIT) begin
            op = LABX_ANDL;
        end else if (instr[LABX_NIB_OP_HI:LABX_NIB_OP_LO]
                     == LABX_OP_BITCLR) begin
            op = LABX_BCLR;
        end
    end

    assign dest_reg = instr[LABX_DEST_POS];
    assign faddr = instr[LABX_FILE_HI:0];
    assign bit_idx = instr[LABX_BIT_HI:LABX_BIT_LO];
    assign literal = instr[LABX_LIT_HI:0];

endmodule // labx_decode

// ===== tb/labx_exec_properties.sv
// Port assertions for the execution datapath.
// Assumes done_r retires one instruction an edge after its take.
`timescale 1ns/1ns
module labx_exec_chk (
    input wire logic clk_sys, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [labx_pkg::LABX_IW-1:0] instr, // Word
    input wire logic instr_valid, // Present
    input wire logic [labx_pkg::LABX_DW-1:0] file_rd, // File data
    input wire logic [labx_pkg::LABX_FAW-1:0] file_addr_r, // Address
    input wire logic [labx_pkg::LABX_DW-1:0] file_wdata_r, // Write data
    input wire logic file_we_r, // Strobe
    input wire logic [labx_pkg::LABX_DW-1:0] acc_r, // Accumulator
    input wire logic zero_flag_r, // Zero
    input wire logic carry_flag_r, // Carry
    input wire logic digit_carry_flag_r, // Nibble carry
    input wire logic done_r // Retired
);
    import labx_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----
    // Retire of each kind, seen one edge after the take
    // ----
    sequence add_s;
        done_r && $past(instr[11:6]) == LABX_OP_ADDWR;
    endsequence
    sequence andr_s;
        done_r && $past(instr[11:6]) == LABX_OP_ANDWR;
    endsequence
    sequence andl_s;
        done_r && $past(instr[11:8]) == LABX_OP_ANDLIT;
    endsequence
    sequence bclr_s;
        done_r && $past(instr[11:8]) == LABX_OP_BITCLR;
    endsequence
    sequence quiet_s;
        !done_r [*3];
    endsequence
    andr_file_a: assert property (
        andr_s ##0 $past(instr[5]) |-> file_we_r
        && file_wdata_r == ($past(acc_r) & $past(file_rd))
        && acc_r == $past(acc_r) && zero_flag_r == (file_wdata_r == 8'h00))
        else $error("and to file");
    andr_acc_a: assert property (
        andr_s ##0 !$past(instr[5]) |-> !file_we_r
        && acc_r == ($past(acc_r) & $past(file_rd))
        && carry_flag_r == $past(carry_flag_r))
        else $error("and to acc");
    andl_acc_a: assert property (
        andl_s |-> !file_we_r
        && acc_r == ($past(acc_r) & $past(instr[7:0]))
        && zero_flag_r == !(|acc_r)
        && carry_flag_r == $past(carry_flag_r))
        else $error("literal and");
    add_acc_a: assert property (
        add_s ##0 !$past(instr[5]) |->
        {carry_flag_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(file_rd)}
        && digit_carry_flag_r == ({1'b0, $past(acc_r[3:0])}
        + {1'b0, $past(file_rd[3:0])} > 5'h0f))
        else $error("add to acc");
    add_file_a: assert property (
        add_s ##0 $past(instr[5]) |-> file_we_r
        && file_wdata_r == 8'($past(acc_r) + $past(file_rd))
        && acc_r == $past(acc_r))
        else $error("add to file");
    bit_clear_a: assert property (
        bclr_s |-> file_we_r
        && file_wdata_r == ($past(file_rd) & ~(8'h01 << $past(instr[7:5])))
        && $stable(zero_flag_r) && $stable(carry_flag_r))
        else $error("clear");
    write_addr_a: assert property (
        file_we_r |-> file_addr_r == $past(instr[4:0]) && done_r)
        else $error("address");
    retire_gap_a: assert property (
        done_r |=> quiet_s)
        else $error("gap");
    retire_cause_a: assert property (
        done_r |-> $past(instr_valid))
        else $error("retire without instruction");
endmodule // labx_exec_chk
bind labx_exec labx_exec_chk u_chk (.clk_sys, .sys_rst, .instr, .instr_valid,
    .file_rd, .file_addr_r, .file_wdata_r, .file_we_r, .acc_r, .zero_flag_r,
    .carry_flag_r, .digit_carry_flag_r, .done_r);

// ===== tb/testbench.sv
// Self-checking bench for the execution datapath.
// Assumes a behavioural register file on file_rd and file_we_r.
`timescale 1ns/1ns
module testbench;
    import labx_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] instr = 12'h000;
    logic instr_valid = 1'b0;
    logic [7:0] regs [32];
    logic [7:0] file_rd, file_wdata_r, acc_r;
    logic [4:0] file_addr_r;
    logic file_we_r, zero_flag_r, carry_flag_r, digit_carry_flag_r, done_r;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    assign file_rd = regs[instr[4:0]];
    labx_exec dut (.clk_sys, .sys_rst, .instr, .instr_valid, .file_rd,
        .file_addr_r, .file_wdata_r, .file_we_r, .acc_r, .zero_flag_r,
        .carry_flag_r, .digit_carry_flag_r, .done_r);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // ----
    // Register file and hang guard
    // ----
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (file_we_r) regs[file_addr_r] <= file_wdata_r;
        if (cyc == 1000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic st(logic [7:0] a, logic [2:0] zcd);
        chk8("acc_r", a, acc_r);
        chk8("flags", {5'h00, zcd},
            {5'h00, zero_flag_r, carry_flag_r, digit_carry_flag_r});
    endtask
    // Holds the request until retire; phase 3 decides the take
    task automatic run(logic [11:0] ins);
        int n;
        instr = ins;
        instr_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (done_r !== 1'b1 && n < 8);
        chk8("done_r", 8'h01, {7'h00, done_r});
        instr_valid = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // One instruction, then accumulator and flags
    task automatic run_chk(logic [11:0] ins, logic [7:0] a, logic [2:0] zcd);
        run(ins);
        st(a, zcd);
    endtask
    task automatic t_add();
        regs[1] = 8'h17;
        regs[2] = 8'hc2;
        regs[3] = 8'he9;
        run_chk(12'h1c1, 8'h17, 3'b000);
        run_chk(12'h1e2, 8'h17, 3'b000);
        chk8("reg2", 8'hd9, regs[2]);
        run_chk(12'h1c3, 8'h00, 3'b111);
        run_chk(12'h1c1, 8'h17, 3'b000);
    endtask
    task automatic t_andr();
        regs[4] = 8'he8;
        run_chk(12'h162, 8'h17, 3'b000);
        chk8("reg2", 8'h11, regs[2]);
        run_chk(12'h144, 8'h00, 3'b100);
        chk8("reg4", 8'he8, regs[4]);
    endtask
    task automatic t_andl();
        regs[5] = 8'ha3;
        regs[6] = 8'hff;
        run_chk(12'h1c5, 8'ha3, 3'b000);
        run_chk(12'he5f, 8'h03, 3'b000);
        run_chk(12'h1c6, 8'h02, 3'b011);
        run_chk(12'he5e, 8'h02, 3'b011);
        run_chk(12'hefd, 8'h00, 3'b111);
    endtask
    task automatic t_bclr();
        regs[31] = 8'hc7;
        run_chk(12'h4ff, 8'h00, 3'b111);
        chk8("reg31", 8'h47, regs[31]);
        run(12'h41f);
        chk8("reg31", 8'h46, regs[31]);
    endtask
    // Unknown opcode retires with no effect
    task automatic t_unk();
        run_chk(12'hf00, 8'h00, 3'b111);
        chk8("reg0", 8'h00, regs[0]);
    endtask
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (6) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        st(8'h00, 3'b000);
        t_add();
        t_andr();
        t_andl();
        t_bclr();
        t_unk();
        tally_and_finish();
    end
endmodule // testbench
